// File: verif/epi_pin_model.sv
// Pin source model standing in for the external interrupt sources
`timescale 1ns/10ps
module epi_pin_model (
	// Clock
	input wire logic clk,
	// Requested levels
	input wire logic [1:0] ext_tgt,
	input wire logic [23:0] pc_tgt,
	// Pins
	output logic [1:0] ext_line,
	output logic [23:0] pins
);
	initial begin
		ext_line = 2'h3;
		pins = '0;
	end
	// Levels move only on an edge, so every pulse or low level spans whole periods
	always @(posedge clk) begin
		ext_line <= ext_tgt;
		pins <= pc_tgt;
	end
endmodule : epi_pin_model

// File: verif/ext_and_pin_change_irq_tb.sv
// Self-checking testbench for the external and pin-change interrupt block
`timescale 1ns/10ps
module ext_and_pin_change_irq_tb;
	logic clk;
	logic srst;
	epi_pkg::epi_bus_s bus;
	logic [7:0] rdata;
	logic gie;
	epi_pkg::epi_ack_s ack;
	logic [epi_pkg::N_VEC-1:0] irq_req;
	logic [1:0] ext_tgt;
	logic [23:0] pc_tgt;
	logic [23:0] msk;
	logic [1:0] ext_line;
	logic [23:0] pins;
	int n_fail;
	int n_compared;

	epi_irq epi_irq_inst (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
		.global_irq_enable(gie), .ack(ack), .irq_req(irq_req), .ext_line(ext_line),
		.change_watched_pin(pins), .group0_pin_mask(msk[7:0]),
		.group1_pin_mask(msk[15:8]), .group2_pin_mask(msk[23:16]));
	epi_pin_model epi_pin_model_inst (.clk(clk), .ext_tgt(ext_tgt), .pc_tgt(pc_tgt),
		.ext_line(ext_line), .pins(pins));

	// ***********************************
	// Shared tasks
	// ***********************************
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One strobe cycle; a read leaves its data in rdata on return
	task automatic acc(input logic [7:0] a, input logic io, input logic wr,
		input logic [7:0] d);
		@(posedge clk);
		#1;
		bus = '{addr: a, io_space: io, wr: wr, rd: ~wr, wdata: d};
		@(posedge clk);
		#1;
		bus = '0;
	endtask : acc

	task automatic rdchk(input logic [7:0] a, input logic io, input logic [7:0] exp);
		acc(a, io, 1'b0, 8'h00);
		chk(rdata, exp);
	endtask : rdchk

	task automatic conclude();
		$display("Compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude

	// ***********************************
	// Scenarios
	// ***********************************
	task automatic t_reset();
		logic [7:0] ofs [5] = '{8'h3b, 8'h3c, 8'h3d, 8'h68, 8'h69};
		foreach (ofs[i]) begin
			rdchk(ofs[i], 1'b0, 8'h00);
		end
		rdchk(8'h1d, 1'b1, 8'h00);
		rdchk(8'h50, 1'b0, 8'h00);
		$display("reset values done");
	endtask : t_reset

	task automatic t_regs();
		acc(8'h3d, 1'b0, 1'b1, 8'hff);
		rdchk(8'h3d, 1'b0, 8'h03);
		acc(8'h68, 1'b0, 1'b1, 8'hff);
		rdchk(8'h68, 1'b0, 8'h07);
		acc(8'h69, 1'b0, 1'b1, 8'hff);
		rdchk(8'h69, 1'b0, 8'h0f);
		acc(8'h1d, 1'b1, 1'b1, 8'h00);
		rdchk(8'h3d, 1'b0, 8'h00);
		acc(8'h68, 1'b0, 1'b1, 8'h00);
		// Beyond the short range must not wrap onto the group enables
		acc(8'h48, 1'b1, 1'b1, 8'hff);
		rdchk(8'h68, 1'b0, 8'h00);
		$display("register access done");
	endtask : t_regs

	task automatic t_edge();
		int m;
		for (int l = 0; l < 2; l++) begin
			for (m = 1; m < 4; m++) begin
				acc(8'h69, 1'b0, 1'b1, 8'(m << (2 * l)));
				acc(8'h3c, 1'b0, 1'b1, 8'h03);
				ext_tgt[l] = 1'b0;
				step(6);
				rdchk(8'h3c, 1'b0, (m == 1 || m == 2) ? 8'(1 << l) : 8'h00);
				acc(8'h3c, 1'b0, 1'b1, 8'h03);
				ext_tgt[l] = 1'b1;
				step(6);
				rdchk(8'h3c, 1'b0, (m == 1 || m == 3) ? 8'(1 << l) : 8'h00);
				acc(8'h3c, 1'b0, 1'b1, 8'h03);
				rdchk(8'h3c, 1'b0, 8'h00);
			end
		end
		$display("edge modes done");
	endtask : t_edge

	task automatic t_level();
		acc(8'h69, 1'b0, 1'b1, 8'h00);
		acc(8'h3d, 1'b0, 1'b1, 8'h01);
		gie = 1'b1;
		ext_tgt[0] = 1'b0;
		step(6);
		chk(8'(irq_req), 8'h01);
		rdchk(8'h3c, 1'b0, 8'h00);
		gie = 1'b0;
		step(2);
		chk(8'(irq_req), 8'h00);
		ext_tgt[0] = 1'b1;
		gie = 1'b1;
		step(4);
		chk(8'(irq_req), 8'h00);
		$display("level mode done");
	endtask : t_level

	task automatic t_gate();
		acc(8'h69, 1'b0, 1'b1, 8'h0c);
		acc(8'h3d, 1'b0, 1'b1, 8'h02);
		gie = 1'b0;
		ext_tgt[1] = 1'b0;
		step(6);
		acc(8'h3c, 1'b0, 1'b1, 8'h03);
		ext_tgt[1] = 1'b1;
		step(6);
		chk(8'(irq_req), 8'h00);
		rdchk(8'h3c, 1'b0, 8'h02);
		gie = 1'b1;
		step(2);
		chk(8'(irq_req), 8'h02);
		ack = '{valid: 1'b1, vec: 3'h1};
		step(1);
		ack = '0;
		step(3);
		chk(8'(irq_req), 8'h00);
		rdchk(8'h3c, 1'b0, 8'h00);
		$display("enable gating done");
	endtask : t_gate

	task automatic t_group();
		acc(8'h3d, 1'b0, 1'b1, 8'h00);
		for (int g = 0; g < 3; g++) begin
			acc(8'h68, 1'b0, 1'b1, 8'(1 << g));
			msk = '0;
			pc_tgt[g * 8] = ~pc_tgt[g * 8];
			step(6);
			rdchk(8'h3b, 1'b0, 8'h00);
			msk[g * 8] = 1'b1;
			pc_tgt[g * 8] = ~pc_tgt[g * 8];
			step(6);
			rdchk(8'h3b, 1'b0, 8'(1 << g));
			chk(8'(irq_req), 8'(4 << g));
			acc(8'h1b, 1'b1, 1'b1, 8'h07);
			step(2);
			chk(8'(irq_req), 8'h00);
			// Second change, then cleared by vector entry instead
			pc_tgt[g * 8] = ~pc_tgt[g * 8];
			step(6);
			ack = '{valid: 1'b1, vec: 3'(2 + g)};
			step(1);
			ack = '0;
			step(2);
			chk(8'(irq_req), 8'h00);
			rdchk(8'h3b, 1'b0, 8'h00);
		end
		$display("pin-change groups done");
	endtask : t_group

	// Clearing write lands in the very cycle the change is detected
	task automatic t_race();
		acc(8'h69, 1'b0, 1'b1, 8'h01);
		acc(8'h3c, 1'b0, 1'b1, 8'h03);
		ext_tgt[0] = 1'b0;
		step(2);
		acc(8'h1c, 1'b1, 1'b1, 8'h01);
		rdchk(8'h1c, 1'b1, 8'h01);
		acc(8'h1c, 1'b1, 1'b1, 8'h01);
		rdchk(8'h1c, 1'b1, 8'h00);
		$display("clear race done");
	endtask : t_race

	// ***********************************
	// Clock, watchdog and main sequence
	// ***********************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Whole run needs well under 2000 cycles
	initial begin
		#100000;
		n_fail++;
		conclude();
	end

	initial begin
		n_fail = 0;
		n_compared = 0;
		srst = 1'b1;
		bus = '0;
		gie = 1'b0;
		ack = '0;
		ext_tgt = 2'h3;
		pc_tgt = '0;
		msk = '0;
		repeat (8) @(posedge clk);
		#1;
		srst = 1'b0;
		t_reset();
		t_regs();
		t_edge();
		t_level();
		t_gate();
		t_group();
		t_race();
		conclude();
	end
endmodule : ext_and_pin_change_irq_tb

// File: verilog/epi_irq.sv
// External line and pin-change interrupt request logic with its register file
// Functional notes
// - Line 1 sense: 00 low, 01 any change, 10 falling, 11 rising.
// - Line 0 sense uses the same encoding in its own two bits.
// - Pins are sampled before edge detection; pulses over one clock are caught.
// - Line 1 request needs its enable and the global interrupt flag.
// - Line 0 request needs its enable and global flag; own vector.
// - Pin activity raises requests even when the pin is an output.
// - An edge or change sets the line flag, bit 1 or bit 0.
// - Line vector requested when flag, enable and global flag are set.
// - Every flag clears on vector entry or on writing one.
// - Line flag stays cleared while its line senses low level.
// - Group 2 enable plus global flag requests on changes of pins 23:16.
// - Group 1 enable plus global flag requests on changes of pins 14:8.
// - Group 0 enable plus global flag requests on changes of pins 7:0.
// - A change on a group pin sets the group flag, bits 2 to 0, only while the group is enabled.
// - Group vector requested when flag, enable and global flag are set.
// - A pin counts toward its group only with its mask bit set.
// - Flag registers and the line enable register also answer at offset minus 0x20.
// - Cleared mask bit disables a pin; set needs group enable too.
// - Enabled low-level line requests for as long as the pin is low.
// - Level path needs no edge history to request; pin-change compares with the previous sample.
`timescale 1ns/10ps
module epi_irq (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register access
	input wire epi_pkg::epi_bus_s bus,
	output logic [7:0] rdata,
	// Core side
	input wire logic global_irq_enable,
	input wire epi_pkg::epi_ack_s ack,
	output logic [epi_pkg::N_VEC-1:0] irq_req,
	// Pins
	input wire logic [epi_pkg::N_EXT-1:0] ext_line,
	input wire logic [epi_pkg::N_PC-1:0] change_watched_pin,
	// Pin masks held elsewhere
	input wire logic [7:0] group0_pin_mask,
	input wire logic [7:0] group1_pin_mask,
	input wire logic [7:0] group2_pin_mask
);

	// ***********************************
	// Pin sampling
	// ***********************************
	logic [epi_pkg::N_EXT-1:0] ext_cur;
	logic [epi_pkg::N_EXT-1:0] ext_prev;
	logic [epi_pkg::N_PC-1:0] pc_cur;
	logic [epi_pkg::N_PC-1:0] pc_prev;

	// Pins read directly, whatever their direction
	epi_pin_sync #(.W(epi_pkg::N_EXT)) u_ext_sync (
		.clk(clk),
		.srst(srst),
		.pin_in(ext_line),
		.cur(ext_cur),
		.prev(ext_prev)
	);

	epi_pin_sync #(.W(epi_pkg::N_PC)) u_pc_sync (
		.clk(clk),
		.srst(srst),
		.pin_in(change_watched_pin),
		.cur(pc_cur),
		.prev(pc_prev)
	);

	// ***********************************
	// Registers
	// ***********************************
	logic [epi_pkg::N_EXT-1:0] ext_en_q, ext_en_d;
	logic [epi_pkg::N_GRP-1:0] grp_en_q, grp_en_d;
	logic [7:0] sense_q, sense_d;
	logic [epi_pkg::N_EXT-1:0] ext_flag_q, ext_flag_d;
	logic [epi_pkg::N_GRP-1:0] grp_flag_q, grp_flag_d;
	logic [7:0] rdata_q, rdata_d;
	logic [epi_pkg::N_VEC-1:0] req_q, req_d;

	epi_pkg::epi_sel_e sel;
	epi_pkg::epi_sense_e line0_sense_field;
	epi_pkg::epi_sense_e line1_sense_field;
	epi_pkg::epi_sense_e sense_of [epi_pkg::N_EXT];
	logic [epi_pkg::N_EXT-1:0] ext_low;
	logic [epi_pkg::N_EXT-1:0] ext_set;
	logic [epi_pkg::N_EXT-1:0] ext_wclr;
	logic [epi_pkg::N_EXT-1:0] ext_ack;
	logic [epi_pkg::N_GRP-1:0] grp_set;
	logic [epi_pkg::N_GRP-1:0] grp_wclr;
	logic [epi_pkg::N_GRP-1:0] grp_ack;
	logic [epi_pkg::N_GRP-1:0][epi_pkg::GRP_W-1:0] pmask;
	logic [epi_pkg::N_PC-1:0] pc_chg;

	// Short I/O addresses fold onto the data-space map
	assign sel = epi_pkg::epi_decode(bus.addr, bus.io_space);
	assign line0_sense_field = epi_pkg::epi_sense_e'(sense_q[1:0]);
	assign line1_sense_field = epi_pkg::epi_sense_e'(sense_q[3:2]);
	assign sense_of[0] = line0_sense_field;
	assign sense_of[1] = line1_sense_field;
	assign pmask[0] = group0_pin_mask;
	assign pmask[1] = group1_pin_mask & epi_pkg::GRP1_PINS;
	assign pmask[2] = group2_pin_mask;
	assign pc_chg = pc_cur ^ pc_prev;

	// ***********************************
	// Configuration registers
	// ***********************************
	always_comb begin
		ext_en_d = ext_en_q;
		grp_en_d = grp_en_q;
		sense_d = sense_q;
		if (bus.wr && sel == epi_pkg::SEL_EXE) begin
			ext_en_d = bus.wdata[epi_pkg::N_EXT-1:0];
		end
		if (bus.wr && sel == epi_pkg::SEL_PCE) begin
			grp_en_d = bus.wdata[epi_pkg::N_GRP-1:0];
		end
		if (bus.wr && sel == epi_pkg::SEL_ESC) begin
			sense_d = bus.wdata & epi_pkg::SENSE_BITS;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ext_en_q <= '0;
			grp_en_q <= '0;
			sense_q <= epi_pkg::RST_VAL;
		end else begin
			ext_en_q <= ext_en_d;
			grp_en_q <= grp_en_d;
			sense_q <= sense_d;
		end
	end

	// ***********************************
	// Trigger detection and flags
	// ***********************************
	always_comb begin
		for (int i = 0; i < epi_pkg::N_EXT; i++) begin
			ext_low[i] = (sense_of[i] == epi_pkg::SENSE_LOW);
			ext_set[i] = epi_pkg::epi_edge_trig(sense_of[i], ext_cur[i], ext_prev[i]);
			ext_wclr[i] = bus.wr && sel == epi_pkg::SEL_EXF && bus.wdata[i];
			ext_ack[i] = ack.valid && ack.vec == 3'(epi_pkg::VEC_EXT0 + i);
			// New trigger beats a clear in the same cycle
			ext_flag_d[i] = ext_set[i] | (ext_flag_q[i] & ~ext_wclr[i] & ~ext_ack[i]);
			// Level mode never leaves a flag behind
			if (ext_low[i]) begin
				ext_flag_d[i] = 1'b0;
			end
		end
		for (int g = 0; g < epi_pkg::N_GRP; g++) begin
			// Masked pins only, and only while the group is enabled
			grp_set[g] = grp_en_q[g] && |(pc_chg[g*epi_pkg::GRP_W +: epi_pkg::GRP_W] & pmask[g]);
			grp_wclr[g] = bus.wr && sel == epi_pkg::SEL_PCF && bus.wdata[g];
			grp_ack[g] = ack.valid && ack.vec == 3'(epi_pkg::VEC_GRP0 + g);
			grp_flag_d[g] = grp_set[g] | (grp_flag_q[g] & ~grp_wclr[g] & ~grp_ack[g]);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ext_flag_q <= '0;
			grp_flag_q <= '0;
		end else begin
			ext_flag_q <= ext_flag_d;
			grp_flag_q <= grp_flag_d;
		end
	end

	// ***********************************
	// Requests and read data
	// ***********************************
	always_comb begin
		for (int i = 0; i < epi_pkg::N_EXT; i++) begin
			// Low level requests straight from the pin, no flag needed
			req_d[epi_pkg::VEC_EXT0 + i] = global_irq_enable && ext_en_q[i] &&
				(ext_low[i] ? ~ext_cur[i] : ext_flag_q[i]);
		end
		for (int g = 0; g < epi_pkg::N_GRP; g++) begin
			req_d[epi_pkg::VEC_GRP0 + g] = global_irq_enable && grp_en_q[g] &&
				grp_flag_q[g];
		end
		rdata_d = rdata_q;
		if (bus.rd) begin
			if (sel == epi_pkg::SEL_PCF) begin
				rdata_d = 8'(grp_flag_q);
			end else if (sel == epi_pkg::SEL_EXF) begin
				rdata_d = 8'(ext_flag_q);
			end else if (sel == epi_pkg::SEL_EXE) begin
				rdata_d = 8'(ext_en_q);
			end else if (sel == epi_pkg::SEL_PCE) begin
				rdata_d = 8'(grp_en_q);
			end else if (sel == epi_pkg::SEL_ESC) begin
				rdata_d = sense_q;
			end else begin
				rdata_d = epi_pkg::RST_VAL;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			req_q <= '0;
			rdata_q <= epi_pkg::RST_VAL;
		end else begin
			req_q <= req_d;
			rdata_q <= rdata_d;
		end
	end

	assign irq_req = req_q;
	assign rdata = rdata_q;

	// ***********************************
	// Assertions
	// ***********************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	localparam logic [7:0] EXF_IO = epi_pkg::EXF_OFS - epi_pkg::IO_BASE;

	sequence s_l1_fall;
		line1_sense_field == epi_pkg::SENSE_FALL && ext_prev[1] && !ext_cur[1];
	endsequence

	sequence s_l0_pulse;
		line0_sense_field == epi_pkg::SENSE_RISE && !ext_cur[0] ##1
		(line0_sense_field == epi_pkg::SENSE_RISE && ext_cur[0]) [*2];
	endsequence

	sequence s_exf_clear0;
		bus.wr && sel == epi_pkg::SEL_EXF && bus.wdata[0];
	endsequence

	property p_l1_fall;
		s_l1_fall |=> ext_flag_q[1];
	endproperty
	a_l1_fall: assert property (p_l1_fall) else $error("line 1 falling edge missed");

	property p_l0_pulse;
		s_l0_pulse |-> ext_flag_q[0] || $past(ext_flag_q[0]);
	endproperty
	a_l0_pulse: assert property (p_l0_pulse) else $error("line 0 pulse lost");

	property p_low_flag;
		line0_sense_field == epi_pkg::SENSE_LOW |=> !ext_flag_q[0];
	endproperty
	a_low_flag: assert property (p_low_flag) else $error("flag set in level mode");

	property p_low_req;
		(line1_sense_field == epi_pkg::SENSE_LOW && ext_en_q[1] && global_irq_enable &&
			!ext_cur[1]) |=> irq_req[epi_pkg::VEC_EXT0 + 1];
	endproperty
	a_low_req: assert property (p_low_req) else $error("level request absent");

	property p_gate;
		irq_req[epi_pkg::VEC_EXT0] |-> $past(global_irq_enable) && $past(ext_en_q[0]);
	endproperty
	a_gate: assert property (p_gate) else $error("line 0 request without enables");

	property p_dispatch;
		(grp_flag_q[2] && grp_en_q[2] && global_irq_enable) |=> irq_req[epi_pkg::VEC_GRP0 + 2];
	endproperty
	a_dispatch: assert property (p_dispatch) else $error("group 2 request absent");

	property p_ack_clear;
		(ack.valid && ack.vec == 3'(epi_pkg::VEC_GRP0) && !grp_set[0]) |=> !grp_flag_q[0];
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("flag kept after entry");

	property p_set_wins;
		s_exf_clear0 ##0 ext_set[0] |=> ext_flag_q[0];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("trigger lost to clear");

	property p_mask_off;
		(!grp_flag_q[0] && (pc_chg[7:0] & group0_pin_mask) == 8'h00 && !ack.valid)
			|=> !grp_flag_q[0];
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("masked pin set a flag");

	property p_io_read;
		(bus.rd && bus.io_space && bus.addr == EXF_IO) |=> rdata_q == 8'($past(ext_flag_q));
	endproperty
	a_io_read: assert property (p_io_read) else $error("short address read wrong");

	property p_grp1_set;
		(grp_en_q[1] && |(pc_chg[epi_pkg::GRP_W +: epi_pkg::GRP_W] & pmask[1]))
			|=> grp_flag_q[1];
	endproperty
	a_grp1_set: assert property (p_grp1_set) else $error("group 1 change missed");

	property p_l1_gate;
		irq_req[epi_pkg::VEC_EXT0 + 1] |-> $past(global_irq_enable) && $past(ext_en_q[1]);
	endproperty
	a_l1_gate: assert property (p_l1_gate) else $error("line 1 request without enables");

	// Request must drop once the pin is high again, else the core re-enters forever
	property p_low_release;
		(line0_sense_field == epi_pkg::SENSE_LOW && ext_cur[0])
			|=> !irq_req[epi_pkg::VEC_EXT0];
	endproperty
	a_low_release: assert property (p_low_release) else $error("level request outlived pin");

endmodule : epi_irq

// File: verilog/epi_pin_sync.sv
// Two-stage pin synchroniser with a third stage holding the previous sample
`timescale 1ns/10ps
module epi_pin_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Pins
	input wire logic [W-1:0] pin_in,
	// Sampled values
	output logic [W-1:0] cur,
	output logic [W-1:0] prev
);

	logic [W-1:0] meta_q;
	logic [W-1:0] cur_q;
	logic [W-1:0] prev_q;

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= '0;
			cur_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= pin_in;
			cur_q <= meta_q;
			prev_q <= cur_q;
		end
	end

	assign cur = cur_q;
	assign prev = prev_q;

endmodule : epi_pin_sync

// File: verilog/epi_pkg.sv
// Package: constants, types and helpers for the external and pin-change interrupt block
package epi_pkg;

	// ***********************************
	// Widths
	// ***********************************
	localparam int N_EXT = 2;
	localparam int N_GRP = 3;
	localparam int GRP_W = 8;
	localparam int N_PC = N_GRP * GRP_W;
	localparam int SENSE_W = 2;
	localparam int N_VEC = N_EXT + N_GRP;

	// ***********************************
	// Register map, data-space byte offsets
	// ***********************************
	localparam logic [7:0] PCF_OFS = 8'h3b;
	localparam logic [7:0] EXF_OFS = 8'h3c;
	localparam logic [7:0] EXE_OFS = 8'h3d;
	localparam logic [7:0] PCE_OFS = 8'h68;
	localparam logic [7:0] ESC_OFS = 8'h69;
	localparam logic [7:0] IO_BASE = 8'h20;
	localparam logic [7:0] IO_MAX = 8'h3f;
	localparam logic [7:0] RST_VAL = 8'h00;

	// Writable bits of each register, the rest read zero
	localparam logic [7:0] EXT_BITS = 8'h03;
	localparam logic [7:0] GRP_BITS = 8'h07;
	localparam logic [7:0] SENSE_BITS = 8'h0f;
	// Group 1 has seven pins, the top mask bit is ignored
	localparam logic [7:0] GRP1_PINS = 8'h7f;

	// ***********************************
	// Vector numbering of the request lines
	// ***********************************
	localparam int VEC_EXT0 = 0;
	localparam int VEC_GRP0 = VEC_EXT0 + N_EXT;

	// ***********************************
	// Types
	// ***********************************
	typedef enum logic [1:0] {
		SENSE_LOW = 2'h0,
		SENSE_ANY = 2'h1,
		SENSE_FALL = 2'h2,
		SENSE_RISE = 2'h3
	} epi_sense_e;

	typedef enum logic [5:0] {
		SEL_NONE = 6'h01,
		SEL_PCF = 6'h02,
		SEL_EXF = 6'h04,
		SEL_EXE = 6'h08,
		SEL_PCE = 6'h10,
		SEL_ESC = 6'h20
	} epi_sel_e;

	typedef struct packed {
		logic [7:0] addr;
		logic io_space;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} epi_bus_s;

	typedef struct packed {
		logic valid;
		logic [2:0] vec;
	} epi_ack_s;

	// ***********************************
	// Helpers
	// ***********************************
	function automatic epi_sel_e epi_decode(input logic [7:0] addr, input logic io_space);
		logic [7:0] a;
		a = io_space ? 8'(addr + IO_BASE) : addr;
		if (io_space && addr > IO_MAX) begin
			return SEL_NONE;
		end else if (a == PCF_OFS) begin
			return SEL_PCF;
		end else if (a == EXF_OFS) begin
			return SEL_EXF;
		end else if (a == EXE_OFS) begin
			return SEL_EXE;
		end else if (a == PCE_OFS) begin
			return SEL_PCE;
		end else if (a == ESC_OFS) begin
			return SEL_ESC;
		end else begin
			return SEL_NONE;
		end
	endfunction : epi_decode

	function automatic logic epi_edge_trig(input epi_sense_e s, input logic cur,
		input logic prev);
		case (s)
			SENSE_ANY: return cur ^ prev;
			SENSE_FALL: return prev & ~cur;
			SENSE_RISE: return cur & ~prev;
			default: return 1'b0;
		endcase
	endfunction : epi_edge_trig

endpackage : epi_pkg
